// ---- hdl/wdg_guard.sv ----
`timescale 1ns/1ps
`default_nettype none

// Function
// - one enables; zero disables only when allowed
// - clearing enable ignored unless change-enable set
// - enable zero within four cycles disables
// - level 2 never disables
// - select doubles period from 16K to 2,048K
// - level 0 accepts select change any time
// - level 0 disable needs the two-step sequence
// - levels 0,1 start disabled, enable freely
// - level 1 select and disable need sequence
// - level 1 protected write loads enable, select
// - level 2 always runs, enable reads one
// - level 2 protected write loads select only
// - change-enable self-clears after four cycles
// - level from legacy and always-on fuses
// - count restarts on kick, disable, reset
// - expiry gives one-cycle reset pulse
module wdg_guard
#(
    parameter int TIMEOUT_BASE = wdg_pkg::TIMEOUT_BASE
)
(
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    // apb answer
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // configuration fuses, high when programmed
    input  wire logic        legacy_compat_fuse,
    input  wire logic        always_on_fuse,
    // watchdog oscillator pin
    input  wire logic        timer_osc,
    // kick from the core, same clock
    input  wire logic        watchdog_kick_instruction,
    // results
    output logic             timer_reset_pulse,
    output logic             timer_running
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    wdg_pkg::wdg_ctrl_s   ctrl;          // stored control register
    wdg_pkg::wdg_level_e  level;         // latched safety level
    logic                 fuse_valid;    // level has been captured
    logic [1:0]           cap_cnt;       // cycles since reset release
    logic [2:0]           win_cnt;       // cycles left in change window
    logic                 osc_prev;      // last synced oscillator level
    logic                 enable_prev;   // running state last cycle

    // ------------------------------------------------------------------------
    // synchronised pins
    // ------------------------------------------------------------------------
    logic [1:0]           fuse_sync;     // {always_on, legacy}
    logic                 osc_sync;      // oscillator level

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    wire        setup     = psel && !penable;               // first phase
    wire        access    = psel && penable && pready;      // completing edge
    wire        wr        = access && pwrite;               // write commits
    wire        hit_ctrl  = (paddr == wdg_pkg::ADDR_CONTROL);
    wire        hit_kick  = (paddr == wdg_pkg::ADDR_KICK);
    wire        hit_stat  = (paddr == wdg_pkg::ADDR_STATUS);
    wire        mapped    = hit_ctrl || hit_kick || hit_stat;
    wire        wr_ctrl   = wr && hit_ctrl;                 // control write
    wire        wr_kick   = wr && hit_kick;                 // software kick

    // ------------------------------------------------------------------------
    // fields of the written byte
    // ------------------------------------------------------------------------
    wire        d_ce      = pwdata[wdg_pkg::POS_CHANGE_EN];
    wire        d_en      = pwdata[wdg_pkg::POS_ENABLE];
    wire [2:0]  d_sel     = pwdata[wdg_pkg::POS_SEL_MSB:wdg_pkg::POS_SEL_LSB];

    // ------------------------------------------------------------------------
    // sequence decode
    // ------------------------------------------------------------------------
    wire        is_lvl0   = (level == wdg_pkg::LEVEL0);
    wire        is_lvl2   = (level == wdg_pkg::LEVEL2);
    wire        opening   = wr_ctrl && d_ce && d_en;
    wire        protect   = wr_ctrl && ctrl.change_en && !d_ce;
    wire        win_end   = ctrl.change_en && (win_cnt == 3'h1);

    // enable as seen by the timer and by software
    wire        eff_en    = ctrl.enable || is_lvl2;

    // oscillator rising edge, from the synced level only
    wire        osc_tick  = osc_sync && !osc_prev;

    // ------------------------------------------------------------------------
    // next control values
    // ------------------------------------------------------------------------
    wdg_pkg::wdg_ctrl_s   next_ctrl;
    logic [2:0]           next_win;

    // apply a write to the control register
    always_comb
    begin
        next_ctrl = ctrl;
        next_win  = win_cnt;
        // window runs down, then closes itself
        if (ctrl.change_en)
        begin
            next_win = win_cnt - 3'h1;
            if (win_end)
                next_ctrl.change_en = 1'b0;
        end
        if (wr_ctrl)
        begin
            // writing one always enables, any level
            if (d_en)
                next_ctrl.enable = 1'b1;
            // level 0 takes select without a sequence
            if (is_lvl0)
                next_ctrl.select = d_sel;
            if (protect)
            begin
                // accepted protected write closes the window
                next_ctrl.change_en = 1'b0;
                next_win            = 3'h0;
                next_ctrl.select    = d_sel;
                // disable only outside level 2
                if (!is_lvl2)
                    next_ctrl.enable = d_en;
            end
            else if (opening)
            begin
                // open or reopen the four-cycle window
                next_ctrl.change_en = 1'b1;
                next_win            = wdg_pkg::WINDOW_CYCLES;
            end
            // an enable-zero write without the window leaves enable alone
            // levels 1 and 2 drop select writes outside the window
        end
    end

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------
    wire [31:0] rd_ctrl = {27'h0, ctrl.change_en, eff_en, ctrl.select};
    wire [31:0] rd_stat = {28'h0, 2'(level), timer_running, ctrl.change_en};
    wire [31:0] rd_data = hit_ctrl ? rd_ctrl : (hit_stat ? rd_stat : 32'h0000_0000);

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    wdg_sync #(.W(2)) u_fuse_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({always_on_fuse, legacy_compat_fuse}),
        .sync_out (fuse_sync)
    );

    wdg_sync #(.W(1)) u_osc_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (timer_osc),
        .sync_out (osc_sync)
    );

    // ------------------------------------------------------------------------
    // fuse capture
    // ------------------------------------------------------------------------
    wdg_pkg::wdg_level_e  fuse_level;

    // always-on wins, then legacy picks level 0
    always_comb
    begin
        if (fuse_sync[1])
            fuse_level = wdg_pkg::LEVEL2;
        else if (fuse_sync[0])
            fuse_level = wdg_pkg::LEVEL0;
        else
            fuse_level = wdg_pkg::LEVEL1;
    end

    // latch level once the synchronisers have settled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_cnt    <= 2'h0;
            fuse_valid <= 1'b0;
            level      <= wdg_pkg::LEVEL1;
        end
        else if (!fuse_valid)
        begin
            cap_cnt <= cap_cnt + 2'h1;
            if (cap_cnt == wdg_pkg::CAPTURE_CYCLES)
            begin
                fuse_valid <= 1'b1;
                level      <= fuse_level;
            end
        end
    end

    // ------------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------------
    // reset leaves the timer disabled with window closed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl.change_en <= 1'b0;
            ctrl.enable    <= wdg_pkg::RST_ENABLE;
            ctrl.select    <= wdg_pkg::RST_SELECT;
            win_cnt        <= 3'h0;
        end
        else
        begin
            ctrl    <= next_ctrl;
            win_cnt <= next_win;
        end
    end

    // ------------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------------
    // one wait-free access phase: ready registered in the setup cycle, high in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (setup)
        begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_data;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // timer side
    // ------------------------------------------------------------------------
    logic expire;                        // period ran out
    wire  disabled_now = enable_prev && !eff_en;
    wire  restart      = watchdog_kick_instruction || wr_kick || disabled_now;

    wdg_timeout #(.BASE(TIMEOUT_BASE)) u_timeout
    (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (eff_en),
        .restart (restart),
        .tick    (osc_tick),
        .select  (ctrl.select),
        .expire  (expire)
    );

    // edge history and registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_prev          <= 1'b0;
            enable_prev       <= 1'b0;
            timer_reset_pulse <= 1'b0;
            timer_running     <= 1'b0;
        end
        else
        begin
            osc_prev          <= osc_sync;
            enable_prev       <= eff_en;
            timer_reset_pulse <= expire;
            timer_running     <= eff_en;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/wdg_pkg.sv ----
// ----------------------------------------------------------------------------
// shared constants and types for the watchdog configuration guard
// ----------------------------------------------------------------------------
package wdg_pkg;

    // ------------------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ------------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CONTROL = 8'h00;  // watchdog_control
    localparam logic [7:0]  ADDR_KICK    = 8'h04;  // write any value: restart count
    localparam logic [7:0]  ADDR_STATUS  = 8'h08;  // level, running, window state

    // ------------------------------------------------------------------------
    // watchdog_control field positions
    // ------------------------------------------------------------------------
    localparam int          POS_CHANGE_EN = 4;     // change-enable bit
    localparam int          POS_ENABLE    = 3;     // enable bit
    localparam int          POS_SEL_MSB   = 2;     // timeout_select_bit2
    localparam int          POS_SEL_LSB   = 0;     // timeout_select_bit0

    // ------------------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------------------
    localparam int          POS_ST_WINDOW = 0;     // change window open
    localparam int          POS_ST_RUN    = 1;     // timer counting
    localparam int          POS_ST_LVL_LO = 2;     // safety level, low bit
    localparam int          POS_ST_LVL_HI = 3;     // safety level, high bit

    // ------------------------------------------------------------------------
    // reset values and timing counts
    // ------------------------------------------------------------------------
    localparam logic [2:0]  RST_SELECT      = 3'h0;      // shortest time-out
    localparam logic        RST_ENABLE      = 1'b0;      // starts disabled
    localparam logic [2:0]  WINDOW_CYCLES   = 3'h4;      // change window length
    localparam logic [1:0]  CAPTURE_CYCLES  = 2'h3;      // fuse settle after reset
    localparam int          TIMEOUT_BASE    = 16384;     // osc cycles at code 000
    localparam int          CNT_W           = 22;        // holds 2,048K cycles

    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {LEVEL0, LEVEL1, LEVEL2} wdg_level_e;

    typedef struct packed {
        logic       change_en;  // window open
        logic       enable;     // stored enable
        logic [2:0] select;     // timeout_select
    } wdg_ctrl_s;

endpackage

// ---- hdl/wdg_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// two-flop synchroniser for pin-level inputs
// ----------------------------------------------------------------------------
module wdg_sync
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;  // first stage, read only by second stage

    // two stages, constants under reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/wdg_timeout.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// timeout counter on watchdog oscillator ticks
// ----------------------------------------------------------------------------
module wdg_timeout
#(
    parameter int BASE = wdg_pkg::TIMEOUT_BASE
)
(
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // control
    input  wire logic                     run,
    input  wire logic                     restart,
    input  wire logic                     tick,
    input  wire logic [2:0]               select,
    // result
    output logic                          expire
);

    logic [wdg_pkg::CNT_W-1:0] count;      // ticks since last restart
    logic [wdg_pkg::CNT_W-1:0] last_tick;  // period minus one
    wire                       at_end;     // final tick of period

    // period doubles per select code step
    assign last_tick = wdg_pkg::CNT_W'((BASE << select) - 1);
    assign at_end    = tick && (count == last_tick);

    // count while running, clear on restart or stop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count  <= '0;
            expire <= 1'b0;
        end
        else
        begin
            expire <= run && !restart && at_end;
            if (!run || restart || at_end)
                count <= '0;
            else if (tick)
                count <= count + 1'b1;
        end
    end

endmodule

`default_nettype wire

// ---- tb/test_watchdog_config_guard.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// self-checking bench for the watchdog configuration guard
// ----------------------------------------------------------------------------
module test_watchdog_config_guard;
    localparam int BASE = 4;              // shortened time-out base
    logic        pclk    = 1'b0;          // 40 mhz clock
    logic        presetn = 1'b0;          // reset, active low
    logic        psel    = 1'b0;          // apb request
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;                  // apb answer
    logic        pready;
    logic        pslverr;
    logic        lg_fuse = 1'b0;          // fuses
    logic        ao_fuse = 1'b0;
    logic        timer_osc = 1'b0;        // oscillator, still between bursts
    logic        kick    = 1'b0;          // core kick
    logic        timer_reset_pulse;       // results
    logic        timer_running;
    int          error_cnt   = 0;         // mismatch count
    int          comparisons = 0;         // comparison count
    int          pulses      = 0;         // reset pulses seen

    wdg_guard #(.TIMEOUT_BASE(BASE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .legacy_compat_fuse(lg_fuse),
        .always_on_fuse(ao_fuse), .timer_osc(timer_osc), .watchdog_kick_instruction(kick),
        .timer_reset_pulse(timer_reset_pulse), .timer_running(timer_running));

    // ------------------------------------------------------------------------
    // clock, pulse counter, watchdog
    // ------------------------------------------------------------------------
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end

    // count expiry pulses
    always @(posedge pclk)
    begin
        if (timer_reset_pulse === 1'b1)
            pulses++;
    end

    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        wrap_up();
    end

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // compare one value
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // control write, control read, status read
    task automatic wc(input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, wdg_pkg::ADDR_CONTROL, d, q, e);
    endtask
    task automatic rc(input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, wdg_pkg::ADDR_CONTROL, 32'h0000_0000, q, e);
        chk(exp, q);
    endtask
    task automatic rs(input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, wdg_pkg::ADDR_STATUS, 32'h0000_0000, q, e);
        chk(exp, q);
    endtask

    // reset with given fuses, then let the level settle
    task automatic boot(input logic lg, input logic ao);
        presetn <= 1'b0;
        lg_fuse <= lg;
        ao_fuse <= ao;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    // n oscillator rising edges, four clocks each
    task automatic osc(input int n);
        repeat (n)
        begin
            timer_osc <= 1'b1;
            repeat (2) @(posedge pclk);
            timer_osc <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_level1();
        logic [31:0] q;
        logic        e;
        boot(1'b0, 1'b0);
        rc(32'h0000_0000);
        rs(32'h0000_0004);
        apb(1'b0, 8'h0c, 32'h0000_0000, q, e);
        chk(32'h0000_0000, q);
        chk(32'h0000_0001, {31'h0, e});
        wc(32'h0000_0008);
        rc(32'h0000_0008);
        wc(32'h0000_0000);
        rc(32'h0000_0008);
        wc(32'h0000_000d);
        rc(32'h0000_0008);
        wc(32'h0000_0018);
        rs(32'h0000_0007);
        wc(32'h0000_0000);
        rc(32'h0000_0008);
        wc(32'h0000_0018);
        wc(32'h0000_0005);
        rc(32'h0000_0005);
        chk(32'h0000_0000, {31'h0, timer_running});
    endtask

    task automatic t_level0();
        boot(1'b1, 1'b0);
        rs(32'h0000_0000);
        wc(32'h0000_000b);
        rc(32'h0000_000b);
        wc(32'h0000_0003);
        rc(32'h0000_000b);
        wc(32'h0000_000e);
        rc(32'h0000_000e);
        wc(32'h0000_0018);
        wc(32'h0000_0000);
        rc(32'h0000_0000);
    endtask

    task automatic t_level2();
        for (int lg = 0; lg < 2; lg++)
        begin
            boot(lg[0], 1'b1);
            rs(32'h0000_000a);
            rc(32'h0000_0008);
            wc(32'h0000_000d);
            rc(32'h0000_0008);
            wc(32'h0000_0018);
            wc(32'h0000_0002);
            rc(32'h0000_000a);
            chk(32'h0000_0001, {31'h0, timer_running});
        end
    endtask

    task automatic t_timeout();
        for (int s = 0; s < 8; s++)
        begin
            boot(1'b1, 1'b0);
            pulses = 0;
            wc(32'h0000_0008 | s);
            osc((BASE << s) - 1);
            repeat (8) @(posedge pclk);
            chk(32'h0000_0000, pulses);
            osc(1);
            repeat (8) @(posedge pclk);
            chk(32'h0000_0001, pulses);
        end
    endtask

    task automatic t_kick();
        logic [31:0] q;
        logic        e;
        boot(1'b1, 1'b0);
        pulses = 0;
        wc(32'h0000_0008);
        osc(BASE - 1);
        repeat (6) @(posedge pclk);
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        osc(BASE - 1);
        repeat (6) @(posedge pclk);
        apb(1'b1, wdg_pkg::ADDR_KICK, 32'h0000_0000, q, e);
        osc(BASE - 1);
        repeat (6) @(posedge pclk);
        chk(32'h0000_0000, pulses);
        osc(1);
        repeat (8) @(posedge pclk);
        chk(32'h0000_0001, pulses);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        t_level1();
        t_level0();
        t_level2();
        t_timeout();
        t_kick();
        wrap_up();
    end
endmodule

`default_nettype wire

// ---- tb/wdg_guard_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// port checker for the watchdog configuration guard
// ----------------------------------------------------------------------------
module wdg_guard_sva
#(
    parameter int TIMEOUT_BASE = wdg_pkg::TIMEOUT_BASE
)
(
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // fuses, oscillator, kick
    input  wire logic        legacy_compat_fuse,
    input  wire logic        always_on_fuse,
    input  wire logic        timer_osc,
    input  wire logic        watchdog_kick_instruction,
    // results
    input  wire logic        timer_reset_pulse,
    input  wire logic        timer_running
);
    // ------------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------------
    logic [3:0] rel_cnt;   // cycles since reset release, saturating
    wire        wr_ctrl;   // committed control write
    wire        mapped;    // address decodes to a register

    assign wr_ctrl = psel && penable && pready && pwrite && (paddr == wdg_pkg::ADDR_CONTROL);
    assign mapped  = (paddr == wdg_pkg::ADDR_CONTROL) || (paddr == wdg_pkg::ADDR_KICK)
                  || (paddr == wdg_pkg::ADDR_STATUS);

    // release counter, level is settled once it saturates
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rel_cnt <= 4'h0;
        else if (rel_cnt != 4'hf)
            rel_cnt <= rel_cnt + 4'h1;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------------
    property p_setup_ready;
        psel && !penable |=> pready;
    endproperty
    property p_ready_access;
        pready |-> psel && penable ##1 !pready;
    endproperty
    property p_slverr;
        pready |-> (pslverr == !mapped);
    endproperty
    property p_upper_zero;
        pready && !pwrite |-> prdata[31:8] == 24'h00_0000;
    endproperty
    property p_pulse_one;
        timer_reset_pulse |=> !timer_reset_pulse;
    endproperty
    property p_pulse_run;
        timer_reset_pulse |-> $past(timer_running);
    endproperty
    property p_level2_run;
        (rel_cnt == 4'hf) && always_on_fuse |-> timer_running;
    endproperty
    property p_level2_read;
        pready && !pwrite && (paddr == wdg_pkg::ADDR_CONTROL) && (rel_cnt == 4'hf)
            && always_on_fuse |-> prdata[wdg_pkg::POS_ENABLE];
    endproperty
    property p_no_silent_off;
        $fell(timer_running) |-> $past(wr_ctrl) || $past(wr_ctrl, 2);
    endproperty

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
    a_ready_access: assert property (p_ready_access) else $error("ready outside access");
    a_slverr: assert property (p_slverr) else $error("slave error wrong for address");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
    a_pulse_run: assert property (p_pulse_run) else $error("pulse while stopped");
    a_level2_run: assert property (p_level2_run) else $error("level 2 stopped");
    a_level2_read: assert property (p_level2_read) else $error("enable reads 0");
    a_no_silent_off: assert property (p_no_silent_off) else $error("timer fell alone");

    // ------------------------------------------------------------------------
    // covers
    // ------------------------------------------------------------------------
    c_wr_ctrl: cover property (wr_ctrl);
    c_pulse: cover property (timer_reset_pulse);
    c_off: cover property ($fell(timer_running));
endmodule

bind wdg_guard wdg_guard_sva #(.TIMEOUT_BASE(TIMEOUT_BASE)) u_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .legacy_compat_fuse(legacy_compat_fuse), .always_on_fuse(always_on_fuse),
    .timer_osc(timer_osc), .watchdog_kick_instruction(watchdog_kick_instruction),
    .timer_reset_pulse(timer_reset_pulse), .timer_running(timer_running));

`default_nettype wire
